/* File: verilog/pm_gpio_port_pin_mux.sv */
// chip pin multiplexer: routes each port pin to gpio or a peripheral
//
// Overview of operation
// - four ports: a has 15 pins, b 14, c 16, d eight.
// - after reset port a is gpio, except bit 7 which is reset input.
// - after reset port d is gpio, except bits 0..3 which are test port.
// - ports b and c reset to gpio; b gets peripherals only when software selects, c has none.
// - a4 selects motor output 4, timer a ch2 or fault input 1.
// - a5 selects motor output 5, timer a ch3 or fault input 2.
// - a6 selects fault input 0 or timer a ch0.
// - a8 selects fault input 1, timer a ch2 or comparator a input 1.
// - a9 selects fault input 2, timer a ch3 or comparator b input 1.
// - a10/a11 select timer b ch2/ch3 or comparator a/b input 2.
// - a12..a14 select serial port 1 signal, a timer b or timer a channel.
// - b0/b1 select serial port 0 clock/select or i2c scl/sda.
// - b2/b3 select serial 0 master in/out, timer a ch2/3, motor source 0/1.
// - b4 has five choices: timer a0, clock out, ss1, timer b0, source 2.
// - b5: timer a1, fault 3, ext clock; b6: async rx, sda, ext clock.
// - external clock on b5/b6 also needs the pll enable.
// - b7 selects async serial 0 transmit or i2c scl.
// - b8/b9 select i2c scl/sda or can transmit/receive.
// - b10 selects timer b ch0 or comparator a output.
`timescale 1ns/100ps
module pm_gpio_port_pin_mux
  import pm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // pads: input level, output level, output enable (low = driving)
  input wire logic [PM_NPINS-1:0] pad_in,
  output logic [PM_NPINS-1:0] pad_out,
  output logic [PM_NPINS-1:0] pad_oe_n,
  // configuration write port
  input wire logic cfg_wr,
  input wire logic [PM_NPINS-1:0] cfg_periph_en,
  input wire logic [PM_SEL_BITS-1:0] cfg_select,
  // clock generator pll control: external clock input enable
  input wire logic pll_ext_clock_en,
  // configuration and status readback
  output logic [PM_NPINS-1:0] periph_en_state,
  output logic [PM_SEL_BITS-1:0] pin_function_select_reg,
  output logic [PM_NPINS-1:0] pin_is_periph_state,
  output logic [PM_NPINS-1:0] select_fault,
  output logic route_conflict,
  // gpio controller side
  input wire logic [PM_NPINS-1:0] gpio_out,
  input wire logic [PM_NPINS-1:0] gpio_dir,
  output logic [PM_NPINS-1:0] gpio_in,
  // peripheral side, indexed by pm_func_e code
  input wire logic [PM_NFUNC-1:0] periph_out,
  input wire logic [PM_NFUNC-1:0] periph_drive,
  output logic [PM_NFUNC-1:0] periph_in
);

  // pick one of up to five listed peripheral choices by field value
  function automatic pm_func_e pm_pick(
    input pm_func_e c0,
    input pm_func_e c1,
    input pm_func_e c2,
    input pm_func_e c3,
    input pm_func_e c4,
    input logic [2:0] s
  );
    pm_func_e f;
    f = F_NONE;
    case (s)
      PM_SEL_CHOICE0: f = c0;
      PM_SEL_CHOICE1: f = c1;
      PM_SEL_CHOICE2: f = c2;
      PM_SEL_CHOICE3: f = c3;
      PM_SEL_CHOICE4: f = c4;
      default: f = F_NONE;
    endcase
    return f;
  endfunction

  // routing table; pins not listed here have no peripheral choice
  function automatic pm_func_e pm_route(
    input int unsigned pin,
    input logic [2:0] s
  );
    pm_func_e f;
    f = F_NONE;
    case (pin)
      // port a
      PM_A_BASE + 4: f = pm_pick(F_MOTOR_OUT_4, F_TIMER_A_CH2, F_FAULT_IN_1,
                                 F_NONE, F_NONE, s);
      PM_A_BASE + 5: f = pm_pick(F_MOTOR_OUT_5, F_TIMER_A_CH3, F_FAULT_IN_2,
                                 F_NONE, F_NONE, s);
      PM_A_BASE + 6: f = pm_pick(F_FAULT_IN_0, F_TIMER_A_CH0, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_A_BASE + 7: f = pm_pick(F_EXT_RESET, F_NONE, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_A_BASE + 8: f = pm_pick(F_FAULT_IN_1, F_TIMER_A_CH2, F_COMPARATOR_A_INPUT1,
                                 F_NONE, F_NONE, s);
      PM_A_BASE + 9: f = pm_pick(F_FAULT_IN_2, F_TIMER_A_CH3, F_COMPARATOR_B_INPUT1,
                                 F_NONE, F_NONE, s);
      PM_A_BASE + 10: f = pm_pick(F_TIMER_B_CH2, F_COMPARATOR_A_INPUT2, F_NONE,
                                  F_NONE, F_NONE, s);
      PM_A_BASE + 11: f = pm_pick(F_TIMER_B_CH3, F_COMPARATOR_B_INPUT2, F_NONE,
                                  F_NONE, F_NONE, s);
      PM_A_BASE + 12: f = pm_pick(F_SYNC_SERIAL1_CLOCK, F_TIMER_B_CH1, F_TIMER_A_CH1,
                                  F_NONE, F_NONE, s);
      PM_A_BASE + 13: f = pm_pick(F_SYNC_SERIAL1_MASTER_IN, F_TIMER_B_CH2,
                                  F_TIMER_A_CH2, F_NONE, F_NONE, s);
      PM_A_BASE + 14: f = pm_pick(F_SYNC_SERIAL1_MASTER_OUT, F_TIMER_B_CH3,
                                  F_TIMER_A_CH3, F_NONE, F_NONE, s);
      // port b
      PM_B_BASE + 0: f = pm_pick(F_SYNC_SERIAL0_CLOCK, F_I2C_SCL, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_B_BASE + 1: f = pm_pick(F_SYNC_SERIAL0_SELECT, F_I2C_SDA, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_B_BASE + 2: f = pm_pick(F_SYNC_SERIAL0_MASTER_IN, F_TIMER_A_CH2,
                                 F_MOTOR_SOURCE_IN_0, F_NONE, F_NONE, s);
      PM_B_BASE + 3: f = pm_pick(F_SYNC_SERIAL0_MASTER_OUT, F_TIMER_A_CH3,
                                 F_MOTOR_SOURCE_IN_1, F_NONE, F_NONE, s);
      PM_B_BASE + 4: f = pm_pick(F_TIMER_A_CH0, F_CLOCK_OUTPUT, F_SYNC_SERIAL1_SELECT,
                                 F_TIMER_B_CH0, F_MOTOR_SOURCE_IN_2, s);
      PM_B_BASE + 5: f = pm_pick(F_TIMER_A_CH1, F_FAULT_IN_3, F_EXTERNAL_CLOCK_INPUT,
                                 F_NONE, F_NONE, s);
      PM_B_BASE + 6: f = pm_pick(F_ASYNC_SERIAL0_RECEIVE, F_I2C_SDA,
                                 F_EXTERNAL_CLOCK_INPUT, F_NONE, F_NONE, s);
      PM_B_BASE + 7: f = pm_pick(F_ASYNC_SERIAL0_TRANSMIT, F_I2C_SCL, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_B_BASE + 8: f = pm_pick(F_I2C_SCL, F_CAN_TX, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_B_BASE + 9: f = pm_pick(F_I2C_SDA, F_CAN_RX, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_B_BASE + 10: f = pm_pick(F_TIMER_B_CH0, F_COMPARATOR_A_OUTPUT, F_NONE,
                                  F_NONE, F_NONE, s);
      // port d test port
      PM_D_BASE + 0: f = pm_pick(F_TEST_DATA_IN, F_NONE, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_D_BASE + 1: f = pm_pick(F_TEST_DATA_OUT, F_NONE, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_D_BASE + 2: f = pm_pick(F_TEST_CLOCK, F_NONE, F_NONE,
                                 F_NONE, F_NONE, s);
      PM_D_BASE + 3: f = pm_pick(F_TEST_MODE_SELECT, F_NONE, F_NONE,
                                 F_NONE, F_NONE, s);
      default: f = F_NONE;
    endcase
    return f;
  endfunction

  // whole state of the block
  typedef struct packed {
    logic [PM_NPINS-1:0] periph_en;
    logic [PM_SEL_BITS-1:0] select;
    logic [PM_NPINS-1:0] pad_out;
    logic [PM_NPINS-1:0] pad_oe_n;
    logic [PM_NPINS-1:0] gpio_in;
    logic [PM_NFUNC-1:0] periph_in;
    logic [PM_NPINS-1:0] is_periph;
    logic [PM_NPINS-1:0] sel_fault;
    logic conflict;
  } pm_state_s;

  pm_state_s st;
  pm_state_s next_st;

  logic [PM_NPINS-1:0] pad_sync;
  pm_func_e pin_func [PM_NPINS];
  logic [PM_NPINS-1:0] pin_periph;
  logic [PM_NPINS-1:0] pin_bad;

  // pad inputs come from outside the clock domain
  pm_sync3 u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw(pad_in),
    .clean(pad_sync)
  );

  // per pin: decode the selected function and whether it may be used
  genvar gi;
  generate
    for (gi = 0; gi < PM_NPINS; gi++) begin : g_pin
      logic blocked;
      assign pin_func[gi] = pm_route(gi, st.select[gi*PM_SELW +: PM_SELW]);
      // external clock also needs the pll enable, else pin stays gpio
      assign blocked = (pin_func[gi] == F_EXTERNAL_CLOCK_INPUT) &&
                       !pll_ext_clock_en;
      // only an enabled pin with a real choice leaves gpio mode
      assign pin_periph[gi] = st.periph_en[gi] && (pin_func[gi] != F_NONE) &&
                              !blocked;
      assign pin_bad[gi] = st.periph_en[gi] && !pin_periph[gi];
    end
  endgenerate

  // next-state logic
  always_comb begin
    logic [PM_NFUNC-1:0] claimed;
    int unsigned fi;
    claimed = '0;
    fi = 0;
    next_st = st;
    // software writes the enables and the select fields together
    if (cfg_wr) begin
      next_st.periph_en = cfg_periph_en;
      next_st.select = cfg_select;
    end
    next_st.periph_in = '0;
    next_st.conflict = 1'b0;
    next_st.is_periph = pin_periph;
    next_st.sel_fault = pin_bad;
    // gpio sees every pad level, whatever the pin is given to
    next_st.gpio_in = pad_sync;
    for (int p = 0; p < PM_NPINS; p++) begin
      if (pin_periph[p]) begin
        fi = int'(pin_func[p]);
        // peripheral owns the pad; it decides when to drive
        next_st.pad_out[p] = periph_out[fi];
        next_st.pad_oe_n[p] = !periph_drive[fi];
        // two pins on one signal: levels are or-ed, flagged for software
        if (claimed[fi]) begin
          next_st.conflict = 1'b1;
        end
        claimed[fi] = 1'b1;
        next_st.periph_in[fi] = next_st.periph_in[fi] | pad_sync[p];
      end else begin
        // plain gpio bit
        next_st.pad_out[p] = gpio_out[p];
        next_st.pad_oe_n[p] = !gpio_dir[p];
      end
    end
  end

  // reset puts every pad in input mode and the documented defaults in place
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st.periph_en <= PM_PERIPH_EN_RST;
      st.select <= PM_SELECT_RST;
      st.pad_out <= '0;
      st.pad_oe_n <= '1;
      st.gpio_in <= '0;
      st.periph_in <= '0;
      st.is_periph <= '0;
      st.sel_fault <= '0;
      st.conflict <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // all outputs straight from state flops
  assign pad_out = st.pad_out;
  assign pad_oe_n = st.pad_oe_n;
  assign periph_en_state = st.periph_en;
  assign pin_function_select_reg = st.select;
  assign pin_is_periph_state = st.is_periph;
  assign select_fault = st.sel_fault;
  assign route_conflict = st.conflict;
  assign gpio_in = st.gpio_in;
  assign periph_in = st.periph_in;

endmodule

/* File: verilog/pm_pkg.sv */
// constants, function codes and reset values for the port pin multiplexer
package pm_pkg;

  // pin counts per port and their place in the flat pin vector
  localparam int unsigned PM_A_PINS = 15;
  localparam int unsigned PM_B_PINS = 14;
  localparam int unsigned PM_C_PINS = 16;
  localparam int unsigned PM_D_PINS = 8;
  localparam int unsigned PM_A_BASE = 0;
  localparam int unsigned PM_B_BASE = PM_A_BASE + PM_A_PINS;
  localparam int unsigned PM_C_BASE = PM_B_BASE + PM_B_PINS;
  localparam int unsigned PM_D_BASE = PM_C_BASE + PM_C_PINS;
  localparam int unsigned PM_NPINS = PM_D_BASE + PM_D_PINS;

  // width of one pin's field in the function-select register
  localparam int unsigned PM_SELW = 3;
  localparam int unsigned PM_SEL_BITS = PM_NPINS * PM_SELW;

  // field encodings: which listed peripheral choice of a pin is taken
  localparam logic [2:0] PM_SEL_CHOICE0 = 3'h0;
  localparam logic [2:0] PM_SEL_CHOICE1 = 3'h1;
  localparam logic [2:0] PM_SEL_CHOICE2 = 3'h2;
  localparam logic [2:0] PM_SEL_CHOICE3 = 3'h3;
  localparam logic [2:0] PM_SEL_CHOICE4 = 3'h4;

  // peripheral signal codes; index into the peripheral-side vectors
  localparam int unsigned PM_NFUNC = 43;
  typedef enum logic [5:0] {
    F_MOTOR_OUT_4 = 6'h00,
    F_MOTOR_OUT_5 = 6'h01,
    F_TIMER_A_CH0 = 6'h02,
    F_TIMER_A_CH1 = 6'h03,
    F_TIMER_A_CH2 = 6'h04,
    F_TIMER_A_CH3 = 6'h05,
    F_TIMER_B_CH0 = 6'h06,
    F_TIMER_B_CH1 = 6'h07,
    F_TIMER_B_CH2 = 6'h08,
    F_TIMER_B_CH3 = 6'h09,
    F_FAULT_IN_0 = 6'h0a,
    F_FAULT_IN_1 = 6'h0b,
    F_FAULT_IN_2 = 6'h0c,
    F_FAULT_IN_3 = 6'h0d,
    F_COMPARATOR_A_INPUT1 = 6'h0e,
    F_COMPARATOR_B_INPUT1 = 6'h0f,
    F_COMPARATOR_A_INPUT2 = 6'h10,
    F_COMPARATOR_B_INPUT2 = 6'h11,
    F_COMPARATOR_A_OUTPUT = 6'h12,
    F_SYNC_SERIAL0_CLOCK = 6'h13,
    F_SYNC_SERIAL0_SELECT = 6'h14,
    F_SYNC_SERIAL0_MASTER_IN = 6'h15,
    F_SYNC_SERIAL0_MASTER_OUT = 6'h16,
    F_SYNC_SERIAL1_CLOCK = 6'h17,
    F_SYNC_SERIAL1_SELECT = 6'h18,
    F_SYNC_SERIAL1_MASTER_IN = 6'h19,
    F_SYNC_SERIAL1_MASTER_OUT = 6'h1a,
    F_ASYNC_SERIAL0_RECEIVE = 6'h1b,
    F_ASYNC_SERIAL0_TRANSMIT = 6'h1c,
    F_I2C_SCL = 6'h1d,
    F_I2C_SDA = 6'h1e,
    F_CAN_TX = 6'h1f,
    F_CAN_RX = 6'h20,
    F_MOTOR_SOURCE_IN_0 = 6'h21,
    F_MOTOR_SOURCE_IN_1 = 6'h22,
    F_MOTOR_SOURCE_IN_2 = 6'h23,
    F_CLOCK_OUTPUT = 6'h24,
    F_EXTERNAL_CLOCK_INPUT = 6'h25,
    F_EXT_RESET = 6'h26,
    F_TEST_DATA_IN = 6'h27,
    F_TEST_DATA_OUT = 6'h28,
    F_TEST_CLOCK = 6'h29,
    F_TEST_MODE_SELECT = 6'h2a,
    F_NONE = 6'h3f
  } pm_func_e;

  // reset: port a bit 7 and port d bits 0..3 start on a peripheral
  localparam logic [PM_NPINS-1:0] PM_PERIPH_EN_RST =
    (53'h1 << (PM_A_BASE + 7)) | (53'hf << PM_D_BASE);
  // choice 0 of those pins is the reset input and the test port
  localparam logic [PM_SEL_BITS-1:0] PM_SELECT_RST = 159'h0;

endpackage

/* File: verilog/pm_sync3.sv */
// three-stage pad input synchroniser with agreement filter
`timescale 1ns/100ps
module pm_sync3
  import pm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // raw pad levels and filtered result
  input wire logic [PM_NPINS-1:0] raw,
  output logic [PM_NPINS-1:0] clean
);

  typedef struct packed {
    logic [PM_NPINS-1:0] s1;
    logic [PM_NPINS-1:0] s2;
    logic [PM_NPINS-1:0] s3;
    logic [PM_NPINS-1:0] held;
  } pm_sync_s;

  pm_sync_s st;
  pm_sync_s next_st;

  // s1 feeds only s2; a change is taken once s2 and s3 agree
  always_comb begin
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.held = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.held);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign clean = st.held;

endmodule

/* File: tb/pm_gpio_port_pin_mux_asserts.sv */
// concurrent checks on the pin multiplexer ports
`timescale 1ns/100ps
module pm_mux_asserts
  import pm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // configuration and drive inputs
  input wire logic cfg_wr,
  input wire logic [PM_NPINS-1:0] cfg_periph_en,
  input wire logic [PM_SEL_BITS-1:0] cfg_select,
  input wire logic pll_ext_clock_en,
  input wire logic [PM_NPINS-1:0] gpio_out,
  input wire logic [PM_NPINS-1:0] gpio_dir,
  input wire logic [PM_NFUNC-1:0] periph_drive,
  // watched outputs
  input wire logic [PM_NPINS-1:0] pad_oe_n,
  input wire logic [PM_NPINS-1:0] pad_out,
  input wire logic [PM_NPINS-1:0] periph_en_state,
  input wire logic [PM_SEL_BITS-1:0] pin_function_select_reg,
  input wire logic [PM_NPINS-1:0] pin_is_periph_state,
  input wire logic [PM_NPINS-1:0] select_fault,
  input wire logic [PM_NPINS-1:0] gpio_in,
  input wire logic [PM_NFUNC-1:0] periph_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // a0 has no peripheral choice at all
  sequence s_a0_req;
    cfg_wr && cfg_periph_en[0] ##1 !cfg_wr;
  endsequence
  // b5 external clock asked for while the pll keeps it off
  sequence s_ext_req;
    cfg_wr && cfg_periph_en[20] && cfg_select[62:60] == 3'h2 && !pll_ext_clock_en
      ##1 !cfg_wr && !pll_ext_clock_en;
  endsequence
  // routing steady two cycles, so both pipelines use the same map
  sequence s_a6_fault;
    pin_is_periph_state[6] && $past(pin_is_periph_state[6])
      && pin_function_select_reg[20:18] == 3'h0 && $past(pin_function_select_reg[20:18]) == 3'h0;
  endsequence
  sequence s_b7_tx;
    pin_is_periph_state[22] && $past(pin_is_periph_state[22])
      && pin_function_select_reg[68:66] == 3'h0 && $past(pin_function_select_reg[68:66]) == 3'h0;
  endsequence
  a_cfg_load: assert property (cfg_wr |=> periph_en_state == $past(cfg_periph_en)
    && pin_function_select_reg == $past(cfg_select)) else $error("config word not loaded");
  a_reset_dflt: assert property ($rose(nrst) |-> periph_en_state == PM_PERIPH_EN_RST
    && pin_function_select_reg == PM_SELECT_RST) else $error("reset routing wrong");
  a_gpio_dir: assert property ($past(nrst) |-> pad_oe_n[0] == !$past(gpio_dir[0]))
    else $error("a0 enable not from gpio");
  a_gpio_level: assert property ($past(nrst) && !pad_oe_n[0] |-> pad_out[0] == $past(gpio_out[0]))
    else $error("a0 level not from gpio");
  a_no_choice: assert property (s_a0_req |=> select_fault[0] && !pin_is_periph_state[0])
    else $error("a0 left gpio");
  a_ext_gate: assert property (s_ext_req |=> select_fault[20] && !pin_is_periph_state[20])
    else $error("clock input routed without pll enable");
  a_a6_input: assert property (s_a6_fault |-> periph_in[F_FAULT_IN_0] == gpio_in[6])
    else $error("fault input 0 not fed from a6");
  a_b7_output: assert property (s_b7_tx |->
    pad_oe_n[22] == !$past(periph_drive[F_ASYNC_SERIAL0_TRANSMIT])) else $error("b7 drive wrong");
endmodule

/* File: tb/pm_board.sv */
// board model: pad wire level from mux drive or the board's own level
`timescale 1ns/100ps
module pm_board
  import pm_pkg::*;
(
  // mux pad drive
  input wire logic [PM_NPINS-1:0] pad_out,
  input wire logic [PM_NPINS-1:0] pad_oe_n,
  // level the board puts on released pads
  input wire logic [PM_NPINS-1:0] board_lvl,
  // resolved pad level
  output logic [PM_NPINS-1:0] pad_in
);
  // released pads show the board level, never the last driven value
  assign pad_in = (pad_oe_n & board_lvl) | (~pad_oe_n & pad_out);
endmodule

/* File: tb/pm_gpio_port_pin_mux_tb_top.sv */
// self-checking bench for the port pin multiplexer
`timescale 1ns/100ps
module pm_gpio_port_pin_mux_tb_top;
  import pm_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, cfg_wr = 1'b0, pll_ext_clock_en = 1'b0, route_conflict;
  logic [PM_NPINS-1:0] cfg_periph_en = '0, gpio_out = '0, gpio_dir = '0, board_lvl = '0;
  logic [PM_NPINS-1:0] pad_in, pad_out, pad_oe_n, periph_en_state, pin_is_periph_state;
  logic [PM_NPINS-1:0] select_fault, gpio_in;
  logic [PM_SEL_BITS-1:0] cfg_select = '0, pin_function_select_reg;
  logic [PM_NFUNC-1:0] periph_out = '0, periph_drive = '0, periph_in;
  int n_mismatch = 0, n_checks = 0;
  integer seed = 32'h36b7;
  // choices per pin from a0 up; b5/b6 choice 2 is the external clock
  string nch = {"0000", "33213322333", "22335332222000", "0000000000000000", "11110000"};
  // routing cases: pin, choice, pll enable, peripheral code
  logic [23:0] rt[$] = '{24'h070026, 24'h2d0027, 24'h2e0028, 24'h2f0029, 24'h30002a,
    24'h04200b, 24'h050001, 24'h06000a, 24'h061002, 24'h08200e, 24'h09200f,
    24'h0a1010, 24'h0b0009, 24'h0c0017, 24'h0d1008, 24'h0e2005,
    24'h0f101d, 24'h100014, 24'h112021, 24'h121005, 24'h130002, 24'h131024,
    24'h132018, 24'h133006, 24'h134023, 24'h140003, 24'h14100d, 24'h142125,
    24'h15001b, 24'h15101e, 24'h152125, 24'h16001c, 24'h16101d,
    24'h17101f, 24'h18001e, 24'h191012};

  always #50 core_clk = ~core_clk;

  pm_board pm_board_inst (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .board_lvl(board_lvl),
    .pad_in(pad_in));
  pm_gpio_port_pin_mux pm_gpio_port_pin_mux_inst (.core_clk(core_clk), .nrst(nrst),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .cfg_wr(cfg_wr),
    .cfg_periph_en(cfg_periph_en), .cfg_select(cfg_select), .pll_ext_clock_en(pll_ext_clock_en),
    .periph_en_state(periph_en_state), .pin_function_select_reg(pin_function_select_reg),
    .pin_is_periph_state(pin_is_periph_state), .select_fault(select_fault),
    .route_conflict(route_conflict), .gpio_out(gpio_out), .gpio_dir(gpio_dir),
    .gpio_in(gpio_in), .periph_out(periph_out), .periph_drive(periph_drive),
    .periph_in(periph_in));

  function automatic logic [52:0] rnd();
    logic [63:0] t;
    t = {$random(seed), $random(seed)};
    return t[52:0];
  endfunction

  // reference: a pin is a peripheral only with a listed, permitted choice
  function automatic void mdl(input logic [52:0] en, input logic [158:0] sel, input logic pll,
      output logic [52:0] per, output logic [52:0] flt);
    int s;
    bit ok;
    for (int p = 0; p < PM_NPINS; p++) begin
      s = sel[3 * p +: 3];
      ok = s < (nch[p] - 8'h30) && !((p == 20 || p == 21) && s == 2 && !pll);
      per[p] = en[p] && ok;
      flt[p] = en[p] && !ok;
    end
  endfunction

  task automatic chk(input logic [158:0] got, input logic [158:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic setcfg(input logic [52:0] en, input logic [158:0] sel, input logic pll);
    logic [52:0] per, flt;
    mdl(en, sel, pll, per, flt);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_periph_en <= en;
    cfg_select <= sel;
    pll_ext_clock_en <= pll;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(periph_en_state, en);
    chk(pin_function_select_reg, sel);
    chk(pin_is_periph_state, per);
    chk(select_fault, flt);
  endtask

  task automatic do_reset();
    logic [52:0] per, flt;
    mdl(PM_PERIPH_EN_RST, PM_SELECT_RST, 1'b0, per, flt);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk(periph_en_state, PM_PERIPH_EN_RST);
    chk(pin_is_periph_state, per);
    $display("reset defaults done");
  endtask

  // one pin on one peripheral: drive out through it, then read back in
  task automatic route(input logic [23:0] e);
    int p, f;
    logic v;
    p = e[23:16];
    f = e[7:0];
    v = 1'($random(seed));
    setcfg(PM_NPINS'(1) << p, PM_SEL_BITS'(e[14:12]) << (3 * p), e[8]);
    chk(route_conflict, 1'b0);
    @(posedge core_clk);
    periph_out[f] <= v;
    periph_drive[f] <= 1'b1;
    board_lvl[p] <= !v;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(pad_oe_n[p], 1'b0);
    chk(pad_out[p], v);
    @(posedge core_clk);
    periph_drive[f] <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk(periph_in[f], !v);
    chk(gpio_in[p], !v);
  endtask

  // gpio controller keeps toggling so the a0 pad sees both levels
  always @(posedge core_clk) begin
    gpio_out <= rnd();
    gpio_dir <= rnd();
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    do_reset();
    repeat (24) begin
      @(posedge core_clk);
      board_lvl <= rnd();
      setcfg(rnd(), {rnd(), rnd(), rnd()}, 1'($random(seed)));
    end
    $display("random configurations done");
    setcfg(PM_NPINS'(1) << 20, PM_SEL_BITS'(3'h2) << 60, 1'b0);
    foreach (rt[i]) route(rt[i]);
    $display("routing table done");
    // two pins claim timer a channel 2: inputs are or-ed and flagged
    setcfg(53'h110, (159'h1 << 12) | (159'h1 << 24), 1'b0);
    chk(route_conflict, 1'b1);
    @(posedge core_clk);
    board_lvl[4] <= 1'b1;
    board_lvl[8] <= 1'b0;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    chk(periph_in[F_TIMER_A_CH2], 1'b1);
    $display("shared signal done");
    do_reset();
    summarize();
  end
endmodule

bind pm_gpio_port_pin_mux pm_mux_asserts pm_mux_asserts_inst (.core_clk(core_clk), .nrst(nrst),
  .cfg_wr(cfg_wr), .cfg_periph_en(cfg_periph_en), .cfg_select(cfg_select),
  .pll_ext_clock_en(pll_ext_clock_en), .gpio_out(gpio_out), .gpio_dir(gpio_dir),
  .periph_drive(periph_drive), .pad_oe_n(pad_oe_n), .pad_out(pad_out),
  .periph_en_state(periph_en_state), .pin_function_select_reg(pin_function_select_reg),
  .pin_is_periph_state(pin_is_periph_state), .select_fault(select_fault), .gpio_in(gpio_in),
  .periph_in(periph_in));
